// ---- logic/isn_ctrl.sv ----
// Slave abort sources, forced slave NACK, DMA request generation and register file
// What this block does
// - Slave transmitter arbitration loss sets bit 12
// - Finished slave read sets bit 13
// - Slave bus loss sets bits 14 and 12
// - Read command while serving read sets 15
// - Forced NACK answers every received slave byte
// - Forced-NACK bytes never enter receive FIFO
// - Otherwise normal ACK; only slave receiver affected
// - Receive DMA requests only when enabled
// - Transmit DMA requests only when enabled
// - Transmit request while level at or below watermark
// - Receive request while level above programmed level
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module isn_ctrl
  import isn_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  // AXI4-Lite write channels
  input  wire logic [7:0]        S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  // AXI4-Lite read channels
  input  wire logic [7:0]        S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // Events from the protocol engine, one-cycle pulses, and the read-serving level
  input  wire logic              SLAVE_TX_ARB_LOST_I,
  input  wire logic              SLAVE_READ_DONE_I,
  input  wire logic              SLAVE_BUS_LOST_I,
  input  wire logic              DATA_CMD_WR_I,
  input  wire logic              DATA_CMD_READ_I,
  input  wire logic              SLAVE_TX_SERVING_I,
  // Slave receive path from the protocol engine
  input  wire logic              SLAVE_RX_ROLE_I,
  input  wire logic              BYTE_DONE_I,
  input  wire logic              NORMAL_NACK_I,
  input  wire logic              RX_PUSH_REQ_I,
  output logic                   RX_PUSH_O,
  output logic                   ACK_NACK_O,
  output logic                   RX_ABORT_O,
  // Bus pins
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OEN_O,
  // FIFO levels and DMA handshake
  input  wire isn_pkg::isn_fifo_t FIFO_LEVEL_I,
  output logic                   RX_DMA_REQ_O,
  output logic                   TX_DMA_REQ_O,
  // Interrupt
  output logic                   IRQ_O
);
  isn_wr_t          wr;              // Register write strobe
  logic             wr_hit;          // Write address mapped
  logic             rd_en;           // Read accepted
  logic [7:0]       rd_addr;         // Read address
  logic [31:0]      rd_data;         // Read decode result
  logic             rd_hit;          // Read address mapped
  logic             forced_nack;     // Forced NACK control
  logic             rx_dma_enable;   // Receive channel enable
  logic             tx_dma_enable;   // Transmit channel enable
  logic [WM_W-1:0]  tx_dma_watermark;
  logic [WM_W-1:0]  rx_dma_watermark;
  logic [N_EV-1:0]  status;          // Sticky events, also abort source bits
  logic [N_EV-1:0]  mask;            // Interrupt mask
  logic [N_EV-1:0]  ev;              // Events this cycle
  logic [1:0]       pins;            // Filtered SCL and SDA
  logic             scl_prev;        // SCL one cycle ago
  logic             scl_fall;        // SCL falling edge seen
  logic             nack_active;     // Forcing applies now

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FALL, ST_ACK_SLOT} isn_ack_t;
  isn_ack_t ack_state;

  // Register bus front end
  isn_axil u_axil (
    .clk_i     (CLOCK_I),
    .rst_i     (SYS_RST_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .wr_o      (wr),
    .wr_hit_i  (wr_hit),
    .rd_en_o   (rd_en),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_hit_i  (rd_hit)
  );

  // Pins come from outside the clock domain
  isn_sync #(.W(2)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .async_i ({SDA_I, SCL_I}),
    .sync_o  (pins)
  );

  // Write address decode; abort source is read only and answers SLVERR on write
  always_comb begin
    case (wr.addr)
      ADDR_NACK_CTRL, ADDR_DMA_EN, ADDR_TX_WM, ADDR_RX_WM,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK: wr_hit = 1'b1;
      default:                      wr_hit = 1'b0;
    endcase
  end

  // Read decode; unused bits read as zero
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (rd_addr)
      ADDR_ABORT_SRC: rd_data[ABORT_LSB +: N_EV] = status;
      ADDR_NACK_CTRL: rd_data[NACK_BIT] = forced_nack;
      ADDR_DMA_EN: begin
        rd_data[DMA_RX_BIT] = rx_dma_enable;
        rd_data[DMA_TX_BIT] = tx_dma_enable;
      end
      ADDR_TX_WM:     rd_data[WM_W-1:0] = tx_dma_watermark;
      ADDR_RX_WM:     rd_data[WM_W-1:0] = rx_dma_watermark;
      ADDR_IRQ_STAT:  rd_data[N_EV-1:0] = status;
      ADDR_IRQ_MASK:  rd_data[N_EV-1:0] = mask;
      default:        rd_hit = 1'b0;
    endcase
  end

  // Control registers; all fields live in byte lane zero
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      forced_nack      <= NACK_RST;
      rx_dma_enable    <= DMA_RST[DMA_RX_BIT];
      tx_dma_enable    <= DMA_RST[DMA_TX_BIT];
      tx_dma_watermark <= WM_RST;
      rx_dma_watermark <= WM_RST;
      mask             <= EV_RST;
    end else if (wr.en && wr.strb[0]) begin
      case (wr.addr)
        ADDR_NACK_CTRL: forced_nack <= wr.data[NACK_BIT];
        ADDR_DMA_EN: begin
          rx_dma_enable <= wr.data[DMA_RX_BIT];
          tx_dma_enable <= wr.data[DMA_TX_BIT];
        end
        ADDR_TX_WM:     tx_dma_watermark <= wr.data[WM_W-1:0];
        ADDR_RX_WM:     rx_dma_watermark <= wr.data[WM_W-1:0];
        ADDR_IRQ_MASK:  mask <= wr.data[N_EV-1:0];
        default:        mask <= mask;
      endcase
    end
  end

  // Event sources gathered per status bit
  always_comb begin
    ev = '0;
    ev[EV_ARB_LOST]  = SLAVE_TX_ARB_LOST_I | SLAVE_BUS_LOST_I;
    ev[EV_READ_DONE] = SLAVE_READ_DONE_I;
    // bus loss flag, arbitration bit above follows it
    ev[EV_BUS_LOST]  = SLAVE_BUS_LOST_I;
    ev[EV_CMD_MIS]   = DATA_CMD_WR_I & DATA_CMD_READ_I & SLAVE_TX_SERVING_I;
  end

  // Sticky status, write one to clear; a new event beats a clear in the same cycle
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      status <= EV_RST;
    end else if (wr.en && wr.strb[0] && wr.addr == ADDR_IRQ_STAT) begin
      status <= (status & ~wr.data[N_EV-1:0]) | ev;
    end else begin
      status <= status | ev;
    end
  end

  // Level interrupt from unmasked status
  assign IRQ_O = |(status & mask);

  // Forcing only matters while this end is the slave receiver
  // role gating
  assign nack_active = forced_nack & SLAVE_RX_ROLE_I;

  assign RX_PUSH_O = RX_PUSH_REQ_I & ~nack_active;

  // SCL edge finder on the filtered pin
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      scl_prev <= 1'b1;
    end else begin
      scl_prev <= pins[0];
    end
  end
  assign scl_fall = scl_prev & ~pins[0];

  // Acknowledge slot: wait for SCL low after the byte, drive for one bit period
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_state <= ST_IDLE;
    end else begin
      case (ack_state)
        ST_IDLE:      if (BYTE_DONE_I) ack_state <= ST_WAIT_FALL;
        ST_WAIT_FALL: if (scl_fall) ack_state <= ST_ACK_SLOT;
        ST_ACK_SLOT:  if (scl_fall) ack_state <= ST_IDLE;
        default:      ack_state <= ST_IDLE;
      endcase
    end
  end

  // Answer latched at the start of the slot
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ACK_NACK_O <= 1'b0;
      RX_ABORT_O <= 1'b0;
    end else begin
      RX_ABORT_O <= 1'b0;
      if (ack_state == ST_WAIT_FALL && scl_fall) begin
        ACK_NACK_O <= nack_active | NORMAL_NACK_I;
        RX_ABORT_O <= nack_active;
      end
    end
  end

  // Open drain: pull low for ACK only; enable is active low
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SDA_OEN_O <= 1'b1;
    end else if (ack_state == ST_WAIT_FALL && scl_fall) begin
      SDA_OEN_O <= nack_active | NORMAL_NACK_I;
    end else if (ack_state == ST_ACK_SLOT && scl_fall) begin
      SDA_OEN_O <= 1'b1;
    end
  end
  assign SDA_O = 1'b0;

  // Requests are combinational so they fall the cycle a level or enable changes;
  // the channel must be set for 16 or 32 bit beats
  // receive request
  assign RX_DMA_REQ_O = rx_dma_enable &
                        (FIFO_LEVEL_I.rx_level > {1'b0, rx_dma_watermark});
  assign TX_DMA_REQ_O = tx_dma_enable &
                        (FIFO_LEVEL_I.tx_level <= {1'b0, tx_dma_watermark});

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_arb_sets: assert property (SLAVE_TX_ARB_LOST_I |=> status[EV_ARB_LOST])
    else $error("arbitration loss not flagged");
  chk_done_sets: assert property (SLAVE_READ_DONE_I |=> status[EV_READ_DONE])
    else $error("read done not flagged");
  chk_bus_lost: assert property (SLAVE_BUS_LOST_I |=>
    status[EV_BUS_LOST] && status[EV_ARB_LOST])
    else $error("bus loss did not set both bits");
  chk_cmd_misuse: assert property (DATA_CMD_WR_I && DATA_CMD_READ_I &&
    SLAVE_TX_SERVING_I |=> status[EV_CMD_MIS])
    else $error("command misuse not flagged");
  chk_forced_nack: assert property (ack_state == ST_WAIT_FALL && scl_fall &&
    forced_nack && SLAVE_RX_ROLE_I |=> ACK_NACK_O && RX_ABORT_O && SDA_OEN_O)
    else $error("forced NACK not given");
  chk_no_push: assert property (forced_nack && SLAVE_RX_ROLE_I |-> !RX_PUSH_O)
    else $error("forced NACK byte pushed");
  chk_normal_ack: assert property (ack_state == ST_WAIT_FALL && scl_fall &&
    !nack_active |=> ACK_NACK_O == $past(NORMAL_NACK_I) && !RX_ABORT_O)
    else $error("normal acknowledge altered");
  chk_rx_gate: assert property (!rx_dma_enable |-> !RX_DMA_REQ_O)
    else $error("receive request while disabled");
  chk_tx_gate: assert property (!tx_dma_enable |-> !TX_DMA_REQ_O)
    else $error("transmit request while disabled");
  chk_tx_level: assert property (tx_dma_enable &&
    FIFO_LEVEL_I.tx_level <= {1'b0, tx_dma_watermark} |-> TX_DMA_REQ_O)
    else $error("transmit request missing");
  chk_rx_level: assert property (rx_dma_enable &&
    FIFO_LEVEL_I.rx_level > {1'b0, rx_dma_watermark} |-> RX_DMA_REQ_O)
    else $error("receive request missing");
  chk_req_stale: assert property (RX_DMA_REQ_O || TX_DMA_REQ_O |->
    (!RX_DMA_REQ_O || FIFO_LEVEL_I.rx_level > {1'b0, rx_dma_watermark}) &&
    (!TX_DMA_REQ_O || FIFO_LEVEL_I.tx_level <= {1'b0, tx_dma_watermark}))
    else $error("stale DMA request");
  chk_slot_ends: assert property (ack_state == ST_ACK_SLOT && scl_fall |=>
    ack_state == ST_IDLE ##0 SDA_OEN_O)
    else $error("acknowledge slot not released");

  cov_forced: cover property (RX_ABORT_O);
  cov_ack: cover property (ack_state == ST_ACK_SLOT && !SDA_OEN_O);
  cov_irq: cover property ($rose(IRQ_O));
  cov_dma: cover property (RX_DMA_REQ_O ##1 !RX_DMA_REQ_O);
endmodule
`default_nettype wire

// ---- logic/isn_pkg.sv ----
// Shared constants and carrier types for the slave abort, forced NACK and DMA request block
`default_nettype none
package isn_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_ABORT_SRC = 8'h80;  // Abort source, read only
  localparam logic [7:0] ADDR_NACK_CTRL = 8'h84;  // Forced slave NACK control
  localparam logic [7:0] ADDR_DMA_EN    = 8'h88;  // DMA channel enables
  localparam logic [7:0] ADDR_TX_WM     = 8'h8C;  // Transmit DMA watermark
  localparam logic [7:0] ADDR_RX_WM     = 8'h90;  // Receive DMA level
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hA0;  // Sticky event status, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hA4;  // Interrupt mask, one enables

  // Event indices inside the status bits
  localparam int EV_ARB_LOST  = 0;  // Slave transmitter lost arbitration
  localparam int EV_READ_DONE = 1;  // Slave read finished
  localparam int EV_BUS_LOST  = 2;  // Slave lost the bus while sending
  localparam int EV_CMD_MIS   = 3;  // Read command written while serving a read
  localparam int N_EV         = 4;

  // Field positions
  localparam int ABORT_LSB  = 12;  // Events sit at bits 15:12 of the abort source
  localparam int NACK_BIT   = 0;
  localparam int DMA_RX_BIT = 0;
  localparam int DMA_TX_BIT = 1;
  localparam int WM_W       = 3;   // Watermark fields are bits 2:0
  localparam int LVL_W      = 4;   // FIFO level counts

  // Reset values
  localparam logic            NACK_RST  = 1'b0;
  localparam logic [1:0]      DMA_RST   = 2'h0;
  localparam logic [WM_W-1:0] WM_RST    = 3'h0;
  localparam logic [N_EV-1:0] EV_RST    = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One register write as seen by the register file
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } isn_wr_t;

  // FIFO fill levels from the controller core
  typedef struct packed {
    logic [LVL_W-1:0] tx_level;
    logic [LVL_W-1:0] rx_level;
  } isn_fifo_t;
endpackage
`default_nettype wire

// ---- logic/isn_sync.sv ----
// Three-stage input synchroniser with agreement filter
`default_nettype none
module isn_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Asynchronous inputs and filtered outputs
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  // Widths below one cannot be served; refused while elaborating
  if (W < 1) begin : g_bad_width
    $error("isn_sync: W must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;  // Metastable stage, read only by s2
      logic s2;  // Second stage
      logic s3;  // Third stage
      // Chain of three flops; output moves only once stages two and three agree
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1        <= 1'b1;
          s2        <= 1'b1;
          s3        <= 1'b1;
          sync_o[g] <= 1'b1;
        end else begin
          s1 <= async_i[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            sync_o[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- logic/isn_axil.sv ----
// AXI4-Lite slave front end producing single-cycle register strobes
`default_nettype none
module isn_axil
  import isn_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Write address and data
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // Write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // Read address and data
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // Register file side
  output isn_pkg::isn_wr_t wr_o,
  input  wire logic        wr_hit_i,
  output logic             rd_en_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_hit_i
);
  logic        aw_got;  // Address captured
  logic        w_got;   // Data captured
  logic [7:0]  aw_q;    // Held address
  logic [31:0] w_q;     // Held data
  logic [3:0]  s_q;     // Held strobes
  logic        wr_go;   // Both halves present

  // Either half may arrive first; each is refused while held or a response waits
  assign awready_o = ~aw_got & ~bvalid_o;
  assign wready_o  = ~w_got & ~bvalid_o;
  assign wr_go     = aw_got & w_got & ~bvalid_o;
  assign wr_o      = '{en: wr_go, addr: aw_q, data: w_q, strb: s_q};
  assign arready_o = ~rvalid_o;
  assign rd_en_o   = arvalid_i & arready_o;
  assign rd_addr_o = araddr_i;

  // Capture write address and data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_q   <= 8'h00;
      w_q    <= 32'h00000000;
      s_q    <= 4'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got <= 1'b1;
        aw_q   <= awaddr_i;
      end else if (wr_go) begin
        aw_got <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_got <= 1'b1;
        w_q   <= wdata_i;
        s_q   <= wstrb_i;
      end else if (wr_go) begin
        w_got <= 1'b0;
      end
    end
  end

  // Write response, one cycle after the register strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_hit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // Read data registered from the decode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h00000000;
      rresp_o  <= RESP_OKAY;
    end else if (rd_en_o) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_hit_i ? rd_data_i : 32'h00000000;
      rresp_o  <= rd_hit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/isn_far_model.sv ----
// Remote bus master model: clocks one acknowledge slot and reads the answer
`default_nettype none
module isn_far_model #(
  parameter int DMA_W = 32
) (
  // Device side of the data pin
  input  wire logic sda_o_i,
  input  wire logic sda_oen_n_i,
  // Bus lines as the device sees them
  output logic      scl_o,
  output logic      sda_line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pull-up: the line is high unless the device pulls it low
  assign sda_line_o = sda_oen_n_i ? 1'b1 : sda_o_i;

  // the DMA side serves only 16 or 32 bit beats
  if (DMA_W != 16 && DMA_W != 32) begin : g_bad_width
    $error("isn_far_model: DMA_W must be 16 or 32");
  end

  // Clock stands high outside frames
  initial scl_o = 1'b1;

  // One slot at 64 ns: fall, sample mid-high, fall, back to idle;
  // clock changes land after the edge's own samples, the answer is read off the edge
  task automatic slot(output logic seen);
    scl_o <= 1'b0;
    #32;
    scl_o <= 1'b1;
    #14;
    seen = sda_line_o;
    #18;
    scl_o <= 1'b0;
    #32;
    scl_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the slave abort, forced NACK and DMA request block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import isn_pkg::*;
  // Clock, reset and bus master signals
  logic        clk, rst, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  // Engine events: arb lost, read done, bus lost, command write, command read
  logic [4:0]  ev;
  logic        serving, role, byte_done, nnack, push_req, push, ack_nack, abort, seen;
  logic        scl, sda_line, sda_pin, sda_oen_n, rx_req, tx_req, irq;
  logic [5:0]  snap;     // Outputs settled at the falling edge
  isn_fifo_t   lvl;
  int          n_fail, tests_run, n_abort, a;
  logic [7:0]  ra [7] = '{ADDR_ABORT_SRC, ADDR_NACK_CTRL, ADDR_DMA_EN, ADDR_TX_WM,
                          ADDR_RX_WM, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
  logic [4:0]  pat [4] = '{5'h01, 5'h02, 5'h04, 5'h18};
  logic [15:0] eab [4] = '{16'h1000, 16'h2000, 16'h5000, 16'h8000};
  logic [3:0]  cs [4] = '{4'h4, 4'h7, 4'hD, 4'h8};  // forced, role, normal, answer

  isn_ctrl DUT (
    .CLOCK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(1'b1),
    .SLAVE_TX_ARB_LOST_I(ev[0]), .SLAVE_READ_DONE_I(ev[1]), .SLAVE_BUS_LOST_I(ev[2]),
    .DATA_CMD_WR_I(ev[3]), .DATA_CMD_READ_I(ev[4]), .SLAVE_TX_SERVING_I(serving),
    .SLAVE_RX_ROLE_I(role), .BYTE_DONE_I(byte_done), .NORMAL_NACK_I(nnack),
    .RX_PUSH_REQ_I(push_req), .RX_PUSH_O(push), .ACK_NACK_O(ack_nack), .RX_ABORT_O(abort),
    .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_pin), .SDA_OEN_O(sda_oen_n),
    .FIFO_LEVEL_I(lvl), .RX_DMA_REQ_O(rx_req), .TX_DMA_REQ_O(tx_req), .IRQ_O(irq));

  isn_far_model far (.sda_o_i(sda_pin), .sda_oen_n_i(sda_oen_n), .scl_o(scl),
                     .sda_line_o(sda_line));

  // Clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sample away from the rising edge so comb outputs have settled
  always @(negedge clk) begin
    snap = {irq, rx_req, tx_req, push, ack_nack, sda_oen_n};
    if (abort !== 1'b0) n_abort++;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    tb = 1'b0;
    // No cycle count is assumed; only the watchdog ends a wait with no answer
    while (tb !== 1'b1) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask

  // Read: hold the address until taken, capture data at the answering edge
  task automatic rdr(input logic [7:0] ad);
    logic ta, tr;
    araddr <= ad;
    arvalid <= 1'b1;
    tr = 1'b0;
    while (tr !== 1'b1) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask

  // Read a register and compare its word
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    rdr(ad);
    chk($sformatf("reg %h", ad), rd, e);
  endtask

  // Verdict in one place
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #80us;
    n_fail++;
    complete_run;
  end

  // Main sequence
  initial begin
    {rst, awvalid, wvalid, arvalid, serving, role, byte_done, nnack, push_req} = 9'h100;
    {awaddr, araddr, wdata, ev, lvl} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, read-only and unmapped places
    foreach (ra[i]) rc(ra[i], 32'h0);
    rdr(8'h40);
    chk("unmapped resp", rsp, RESP_SLVERR);
    wr(ADDR_ABORT_SRC, 32'hFFFF);
    chk("ro resp", rsp, RESP_SLVERR);
    rc(ADDR_ABORT_SRC, 32'h0);
    wr(ADDR_TX_WM, 32'hFFFFFFFF);
    rc(ADDR_TX_WM, 32'h7);
    $display("test registers done");
    // Abort sources; only status bit 0 is unmasked
    wr(ADDR_IRQ_MASK, 32'h1);
    ev <= 5'h18;
    @(posedge clk);
    ev <= 5'h0;
    rc(ADDR_ABORT_SRC, 32'h0);
    serving <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ev <= pat[i];
      @(posedge clk);
      ev <= 5'h0;
      rc(ADDR_ABORT_SRC, eab[i]);
      chk("irq set", snap[5], eab[i][12]);
      wr(ADDR_IRQ_STAT, 32'hF);
      rc(ADDR_ABORT_SRC, 32'h0);
      chk("irq clear", snap[5], 1'b0);
    end
    serving <= 1'b0;
    $display("test abort sources done");
    // DMA requests for every enable pair and level 0..8
    wr(ADDR_TX_WM, 32'h3);
    wr(ADDR_RX_WM, 32'h2);
    rc(ADDR_RX_WM, 32'h2);
    for (int en = 0; en < 4; en++) begin
      wr(ADDR_DMA_EN, en);
      rc(ADDR_DMA_EN, en);
      for (int l = 0; l < 9; l++) begin
        lvl <= {4'(l), 4'(l)};
        @(posedge clk);
        chk("tx req", snap[3], en[1] && l <= 3);
        chk("rx req", snap[4], en[0] && l > 2);
      end
    end
    lvl <= '0;
    wr(ADDR_DMA_EN, 32'h0);
    chk("tx req off", snap[3], 1'b0);
    $display("test dma done");
    // A reset in mid-run drops a standing request and clears the controls
    wr(ADDR_DMA_EN, 32'h3);
    chk("tx req on", snap[3], 1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("tx req reset", snap[3], 1'b0);
    rc(ADDR_DMA_EN, 32'h0);
    rc(ADDR_TX_WM, 32'h0);
    $display("test mid-run reset done");
    // Acknowledge slot and receive push for four of the forced/role/normal cases
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_NACK_CTRL, cs[i][3]);
      rc(ADDR_NACK_CTRL, cs[i][3]);
      role <= cs[i][2];
      nnack <= cs[i][1];
      push_req <= 1'b1;
      @(posedge clk);
      push_req <= 1'b0;
      chk("push", snap[2], !(cs[i][3] && cs[i][2]));
      a = n_abort;
      byte_done <= 1'b1;
      @(posedge clk);
      byte_done <= 1'b0;
      far.slot(seen);
      @(posedge clk);
      chk("wire answer", seen, cs[i][0]);
      chk("answer", snap[1], cs[i][0]);
      chk("abort", n_abort - a, cs[i][3] && cs[i][2]);
      chk("released", snap[0], 1'b1);
    end
    $display("test forced nack done");
    complete_run;
  end
endmodule
`default_nettype wire
